// ==== ivsu_top.sv ====
// Interrupt vector selection, priority and register stacking for an 8-bit CPU.
// Assumes the CPU marks instruction ends, supplies its registers and stack
// pointer, performs the stack writes and vector fetch this unit requests.
//
// Notes on behaviour
// - Each source has a fixed two-byte vector, maskables low, reset highest.
// - Twenty-three vectors; seventeen maskable requests taken only while global mask clear.
// - Illegal opcode, soft trap and nonmaskable pin ignore the global mask.
// - Receive-full flag clears on status read while set, then data read.
// - Recognised requests are serviced only when the current instruction ends.
// - Stack PC low, high, Y low, high, X low, high, A, B, codes downward.
// - After codes stacked set global mask, nonmaskable mask if pin serviced; fetch vector.
// - Reset sets both the nonmaskable and global mask bits.
// - Accumulator transfer may clear nonmaskable mask, never set it; reset and pin, watchdog or clock monitor service set it.
// - Nonmaskable pin ranks above all maskables, which keep their own order.
// - Maskable service sets global mask and leaves nonmaskable mask alone.
// - Nonmaskable pin service sets both mask bits.
// - Illegal opcode trap stacks address of the opcode's first byte.
// - Soft trap runs uninterrupted, ignores masks, sets the global mask.
// - External maskable pin is low-level sensitive; events set a readable flag.
// - Priority select promotes one maskable source; writable only while global mask set.
// - Reset and reserved priority codes promote the external request pin.
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

module ivsu_top
    import ivsu_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            ce_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    output logic                 irq_o,
    input  wire logic            irq_pin_n_i,
    input  wire logic            nonmaskable_request_pin_n_i,
    input  wire logic [15:0]     periph_req_i,
    input  wire logic            watchdog_fail_i,
    input  wire logic            clock_monitor_fail_i,
    input  wire logic            soft_trap_i,
    input  wire logic            illegal_op_i,
    input  wire logic [15:0]     op_addr_i,
    input  wire logic            insn_done_i,
    input  wire logic            tap_i,
    input  wire logic [7:0]      tap_data_i,
    input  wire ivsu_cpu_regs_t  cpu_regs_i,
    input  wire logic [15:0]     sp_i,
    input  wire logic            rx_full_set_i,
    input  wire logic [7:0]      rx_data_i,
    output ivsu_stack_wr_t       stk_o,
    output ivsu_vec_fetch_t      vec_o,
    output logic      [15:0]     new_sp_o,
    output logic                 cpu_hold_o,
    output logic                 gmask_o,
    output logic                 nmask_o
);

    ivsu_regs_t r;
    ivsu_regs_t n;

    // Source index promoted by a priority select code
    function automatic logic [4:0] promoted_idx(input logic [4:0] code);
        logic [4:0] idx;
        idx = IRQ_PIN_IDX;
        if (code >= PSEL_FIRST && code <= PSEL_LAST) begin
            idx = 5'(PSEL_LAST - code);
        end
        return idx;
    endfunction : promoted_idx

    // Winning maskable source index
    function automatic logic [4:0] pick_mask(input logic [NMASK-1:0] req,
                                             input logic [4:0] code);
        logic [4:0] idx;
        logic [4:0] prom;
        idx  = '0;
        prom = promoted_idx(code);
        for (int i = 0; i < NMASK; i++) begin
            if (req[i]) begin
                idx = 5'(i);
            end
        end
        if (req[prom]) begin
            idx = prom;
        end
        return idx;
    endfunction : pick_mask

    logic [NMASK-1:0] mask_req;
    logic             mask_any;
    logic [4:0]       mask_idx;
    logic             wb_req;
    logic [NEV-1:0]   ev_set;
    logic [NEV-1:0]   ev_clr;

    // Maskable request vector and bus strobes
    always_comb begin
        mask_req = {r.irq_lvl, periph_req_i};
        mask_any = (|mask_req) && !r.gmask;
        mask_idx = pick_mask(mask_req, r.psel);
        wb_req   = wb_cyc_i && wb_stb_i;
    end

    // Next state of the whole unit
    always_comb begin
        n      = r;
        ev_set = '0;
        ev_clr = '0;
        if (ce_i) begin
            n.stk.valid = 1'b0;
            n.vf.valid  = 1'b0;
            n.ack       = 1'b0;

            // Pin synchronisers, level taken once stages two and three agree
            n.irq_sync = {r.irq_sync[1:0], irq_pin_n_i};
            n.nmr_sync = {r.nmr_sync[1:0], nonmaskable_request_pin_n_i};
            if (r.irq_sync[1] == r.irq_sync[2]) begin
                n.irq_lvl = !r.irq_sync[2];
            end
            if (r.nmr_sync[1] == r.nmr_sync[2]) begin
                n.nmr_lvl = !r.nmr_sync[2];
            end

            // Latch instruction-synchronous requests
            n.pend[PD_ILLEGAL]  = r.pend[PD_ILLEGAL] | illegal_op_i;
            n.pend[PD_SOFT]     = r.pend[PD_SOFT] | soft_trap_i;
            n.pend[PD_WATCHDOG] = r.pend[PD_WATCHDOG] | watchdog_fail_i;
            n.pend[PD_CLKMON]   = r.pend[PD_CLKMON] | clock_monitor_fail_i;

            ev_set[EV_IRQ_PIN]  = r.irq_lvl;
            ev_set[EV_NMR]      = r.nmr_lvl;
            ev_set[EV_ILLEGAL]  = illegal_op_i;
            ev_set[EV_SOFT]     = soft_trap_i;
            ev_set[EV_WATCHDOG] = watchdog_fail_i;
            ev_set[EV_CLKMON]   = clock_monitor_fail_i;

            // transfer may clear, never set, the nonmaskable mask
            if (tap_i && r.state == ST_IDLE) begin
                n.nmask = r.nmask & tap_data_i[CC_NMASK_BIT];
                n.gmask = tap_data_i[CC_GMASK_BIT];
            end

            unique case (r.state)
                ST_IDLE: begin
                    if (insn_done_i) begin
                        n.sp      = sp_i;
                        n.snap    = cpu_regs_i;
                        n.step    = '0;
                        n.via_nmr = 1'b0;
                        n.stacked = 1'b1;
                        if (n.pend[PD_WATCHDOG] || n.pend[PD_CLKMON]) begin
                            // Reset-type: no stacking, vector only
                            n.stacked = 1'b0;
                            n.hold    = 1'b1;
                            n.state   = ST_VECT;
                            n.nmask   = 1'b1;
                            n.gmask   = 1'b1;
                            if (n.pend[PD_CLKMON]) begin
                                n.vec                 = VEC_CLKMON;
                                n.pend[PD_CLKMON]     = 1'b0;
                            end else begin
                                n.vec                 = VEC_WATCHDOG;
                                n.pend[PD_WATCHDOG]   = 1'b0;
                            end
                        end else if (n.pend[PD_ILLEGAL]) begin
                            n.hold              = 1'b1;
                            n.state             = ST_STACK;
                            n.vec               = VEC_ILLEGAL;
                            // return to the opcode's first byte
                            n.snap.pc           = op_addr_i;
                            n.pend[PD_ILLEGAL]  = 1'b0;
                        end else if (n.pend[PD_SOFT]) begin
                            n.hold           = 1'b1;
                            n.state          = ST_STACK;
                            n.vec            = VEC_SOFT_TRAP;
                            n.pend[PD_SOFT]  = 1'b0;
                        end else if (r.nmr_lvl && !r.nmask) begin
                            n.hold    = 1'b1;
                            n.state   = ST_STACK;
                            n.vec     = VEC_NMR;
                            n.via_nmr = 1'b1;
                        end else if (mask_any) begin
                            n.hold  = 1'b1;
                            n.state = ST_STACK;
                            n.vec   = VEC_MASK_BASE + {10'h000, mask_idx, 1'b0};
                        end
                        if (n.hold) begin
                            ev_set[EV_SERVICE] = 1'b1;
                        end
                    end
                end
                ST_STACK: begin
                    // push downward one byte per cycle
                    n.stk.valid = 1'b1;
                    n.stk.addr  = r.sp - {12'h000, r.step};
                    unique case (r.step)
                        4'h0:    n.stk.data = r.snap.pc[7:0];
                        4'h1:    n.stk.data = r.snap.pc[15:8];
                        4'h2:    n.stk.data = r.snap.y[7:0];
                        4'h3:    n.stk.data = r.snap.y[15:8];
                        4'h4:    n.stk.data = r.snap.x[7:0];
                        4'h5:    n.stk.data = r.snap.x[15:8];
                        4'h6:    n.stk.data = r.snap.a;
                        4'h7:    n.stk.data = r.snap.b;
                        default: begin
                            n.stk.data = '0;
                            n.stk.data[CC_NMASK_BIT] = r.nmask;
                            n.stk.data[CC_GMASK_BIT] = r.gmask;
                        end
                    endcase
                    n.step = r.step + 4'h1;
                    if (r.step == STACK_LAST) begin
                        n.state = ST_VECT;
                        n.gmask = 1'b1;
                        n.nmask = r.nmask | r.via_nmr;
                    end
                end
                ST_VECT: begin
                    n.vf.valid = 1'b1;
                    n.vf.addr  = r.vec;
                    n.new_sp   = r.stacked ? (r.sp - STACK_DEPTH) : r.sp;
                    n.hold     = 1'b0;
                    n.state    = ST_IDLE;
                end
                default: begin
                    n.state = ST_IDLE;
                    n.hold  = 1'b0;
                end
            endcase

            // Serial receive flag, set wins over clear
            if (rx_full_set_i) begin
                n.rx_full = 1'b1;
            end

            // Register bus: answer one cycle after request, act at ack edge
            if (wb_req && !r.ack) begin
                n.ack = 1'b1;
                n.dat = '0;
                unique case (wb_adr_i)
                    ADR_PRIO:     n.dat[4:0]     = r.psel;
                    ADR_STATUS:   n.dat[NEV-1:0] = r.status;
                    ADR_MASK:     n.dat[NEV-1:0] = r.mask;
                    ADR_SER_STAT: n.dat[0]       = r.rx_full;
                    ADR_SER_DATA: n.dat[7:0]     = rx_data_i;
                    ADR_CC: begin
                        n.dat[CC_NMASK_BIT] = r.nmask;
                        n.dat[CC_GMASK_BIT] = r.gmask;
                    end
                    default:      n.dat = '0;
                endcase
            end
            if (wb_req && r.ack) begin
                if (wb_we_i && wb_sel_i[0]) begin
                    // priority select locked unless global mask set
                    if (wb_adr_i == ADR_PRIO && r.gmask) begin
                        n.psel = wb_dat_i[4:0];
                    end
                    if (wb_adr_i == ADR_MASK) begin
                        n.mask = wb_dat_i[NEV-1:0];
                    end
                end else if (!wb_we_i) begin
                    if (wb_adr_i == ADR_STATUS) begin
                        ev_clr = r.dat[NEV-1:0];
                    end
                    // status read arms, data read clears
                    if (wb_adr_i == ADR_SER_STAT && r.rx_full) begin
                        n.rx_armed = 1'b1;
                    end
                    if (wb_adr_i == ADR_SER_DATA && r.rx_armed) begin
                        n.rx_armed = 1'b0;
                        n.rx_full  = rx_full_set_i;
                    end
                end
            end

            // Sticky status, set wins over read clear
            n.status = (r.status & ~ev_clr) | ev_set;
            n.irq    = |(n.status & n.mask);
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= REGS_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from flops
    assign wb_dat_o   = r.dat;
    assign wb_ack_o   = r.ack;
    assign irq_o      = r.irq;
    assign stk_o      = r.stk;
    assign vec_o      = r.vf;
    assign new_sp_o   = r.new_sp;
    assign cpu_hold_o = r.hold;
    assign gmask_o    = r.gmask;
    assign nmask_o    = r.nmask;

endmodule : ivsu_top

// ==== ivsu_pkg.sv ====
// Constants, types and register layout of the interrupt vector and stacking unit.
// Assumes a single 40 MHz clock domain and a classic Wishbone register bus.
package ivsu_pkg;

    // Maskable sources: 16 on-chip requests plus the external request pin
    localparam int          NMASK          = 17;
    localparam logic [4:0]  IRQ_PIN_IDX    = 5'h10;

    // Vector locations
    localparam logic [15:0] VEC_MASK_BASE  = 16'hffd2;
    localparam logic [15:0] VEC_NMR        = 16'hfff4;
    localparam logic [15:0] VEC_SOFT_TRAP  = 16'hfff6;
    localparam logic [15:0] VEC_ILLEGAL    = 16'hfff8;
    localparam logic [15:0] VEC_WATCHDOG   = 16'hfffa;
    localparam logic [15:0] VEC_CLKMON     = 16'hfffc;
    localparam logic [15:0] VEC_RESET      = 16'hfffe;

    // Stacking: nine bytes, last one at SP - 8
    localparam logic [3:0]  STACK_LAST     = 4'h8;
    localparam logic [15:0] STACK_DEPTH    = 16'h0009;

    // Priority select codes
    localparam logic [4:0]  PSEL_RST       = 5'h06;
    localparam logic [4:0]  PSEL_FIRST     = 5'h07;
    localparam logic [4:0]  PSEL_LAST      = 5'h16;

    // Mask bit positions within a condition code byte
    localparam int          CC_NMASK_BIT   = 6;
    localparam int          CC_GMASK_BIT   = 4;

    // Register byte offsets
    localparam logic [7:0]  ADR_PRIO       = 8'h00;
    localparam logic [7:0]  ADR_STATUS     = 8'h04;
    localparam logic [7:0]  ADR_MASK       = 8'h08;
    localparam logic [7:0]  ADR_CC         = 8'h0c;
    localparam logic [7:0]  ADR_SER_STAT   = 8'h10;
    localparam logic [7:0]  ADR_SER_DATA   = 8'h14;

    // Event bits of the status and mask registers
    localparam int          NEV            = 7;
    localparam int          EV_IRQ_PIN     = 0;
    localparam int          EV_NMR         = 1;
    localparam int          EV_ILLEGAL     = 2;
    localparam int          EV_SOFT        = 3;
    localparam int          EV_WATCHDOG    = 4;
    localparam int          EV_CLKMON      = 5;
    localparam int          EV_SERVICE     = 6;

    // Latched synchronous request bits
    localparam int          PD_ILLEGAL     = 0;
    localparam int          PD_SOFT        = 1;
    localparam int          PD_WATCHDOG    = 2;
    localparam int          PD_CLKMON      = 3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_STACK = 3'b010,
        ST_VECT  = 3'b100
    } ivsu_state_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] y;
        logic [15:0] x;
        logic [7:0]  a;
        logic [7:0]  b;
    } ivsu_cpu_regs_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } ivsu_stack_wr_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } ivsu_vec_fetch_t;

    typedef struct packed {
        ivsu_state_t     state;
        logic [3:0]      step;
        logic [15:0]     sp;
        ivsu_cpu_regs_t  snap;
        logic [15:0]     vec;
        logic            stacked;
        logic            via_nmr;
        logic            nmask;
        logic            gmask;
        logic [4:0]      psel;
        logic [3:0]      pend;
        logic [NEV-1:0]  status;
        logic [NEV-1:0]  mask;
        logic            rx_full;
        logic            rx_armed;
        logic [2:0]      irq_sync;
        logic [2:0]      nmr_sync;
        logic            irq_lvl;
        logic            nmr_lvl;
        logic            ack;
        logic [31:0]     dat;
        ivsu_stack_wr_t  stk;
        ivsu_vec_fetch_t vf;
        logic [15:0]     new_sp;
        logic            hold;
        logic            irq;
    } ivsu_regs_t;

    // Reset: both masks set, reset vector fetched first
    localparam ivsu_regs_t REGS_RST = '{
        state    : ST_VECT,
        vec      : VEC_RESET,
        nmask    : 1'b1,
        gmask    : 1'b1,
        psel     : PSEL_RST,
        irq_sync : 3'b111,
        nmr_sync : 3'b111,
        hold     : 1'b1,
        default  : '0
    };

endpackage : ivsu_pkg

// ==== ivsu_properties.sv ====
// Port-level checks of the interrupt vector and stacking unit.
// Assumes ce_i stays high; bound into ivsu_top at the foot of this file.
`timescale 1ns/1ps

module ivsu_properties
    import ivsu_pkg::*;
(
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_ack_o,
    input wire logic            insn_done_i,
    input wire ivsu_stack_wr_t  stk_o,
    input wire ivsu_vec_fetch_t vec_o,
    input wire logic [15:0]     new_sp_o,
    input wire logic            cpu_hold_o,
    input wire logic            gmask_o,
    input wire logic            nmask_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Entry: nine stacked bytes then the vector, or the vector alone
    sequence s_stack;
        stk_o.valid [*8] ##1 stk_o.valid ##1 vec_o.valid;
    endsequence
    sequence s_bare;
        vec_o.valid && !stk_o.valid;
    endsequence

    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) // Bus answer
        else $error("no ack one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) // Bus answer
        else $error("ack longer than one cycle");
    a_entry_order: assert property ($rose(cpu_hold_o) |=> s_stack or s_bare)
        else $error("entry sequence broken");
    a_stack_down: assert property (stk_o.valid && $past(stk_o.valid)
        |-> stk_o.addr == $past(stk_o.addr) - 16'h0001)
        else $error("stack address not descending");
    a_sp_after: assert property (vec_o.valid && $past(stk_o.valid)
        |-> new_sp_o == $past(stk_o.addr) - 16'h0001)
        else $error("new stack pointer wrong");
    a_vec_range: assert property (vec_o.valid |-> vec_o.addr >= VEC_MASK_BASE && !vec_o.addr[0])
        else $error("vector outside table");
    a_vec_gmask: assert property (vec_o.valid |=> gmask_o)
        else $error("global mask clear after entry");
    a_nmask_sticky: assert property ($rose(nmask_o) |-> cpu_hold_o)
        else $error("nonmaskable mask set outside entry");
    a_hold_ends: assert property (vec_o.valid |=> !cpu_hold_o)
        else $error("hold kept after vector");
    a_hold_cause: assert property ($rose(cpu_hold_o) |-> $past(insn_done_i))
        else $error("service began mid instruction");
endmodule : ivsu_properties

bind ivsu_top ivsu_properties ivsu_properties_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .insn_done_i, .stk_o, .vec_o, .new_sp_o, .cpu_hold_o, .gmask_o, .nmask_o);

// ==== ivsu_src_model.sv ====
// Far-side model: peripheral request levels, request pins, fail pulses.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps

module ivsu_src_model (
    input  wire logic        clk_i,
    output logic [15:0]      periph_req_o,
    output logic             irq_pin_n_o,
    output logic             nmr_pin_n_o,
    output logic             wd_fail_o,
    output logic             cm_fail_o
);
    initial begin
        periph_req_o = 16'h0000;
        irq_pin_n_o = 1'b1;
        nmr_pin_n_o = 1'b1;
        wd_fail_o = 1'b0;
        cm_fail_o = 1'b0;
    end

    // Levels stand until the bench clears the source
    task automatic set_lines(input logic [15:0] req, input logic irq_n, input logic nmr_n);
        periph_req_o <= req;
        irq_pin_n_o <= irq_n;
        nmr_pin_n_o <= nmr_n;
    endtask : set_lines

    // One-cycle watchdog or clock monitor failure
    task automatic fail_pulse(input logic wd, input logic cm);
        wd_fail_o <= wd;
        cm_fail_o <= cm;
        @(posedge clk_i);
        wd_fail_o <= 1'b0;
        cm_fail_o <= 1'b0;
    endtask : fail_pulse
endmodule : ivsu_src_model

// ==== tb_interrupt_vector_and_stacking_unit.sv ====
// Self-checking bench of the interrupt vector and stacking unit.
// Assumes the package, top module, source model and checker are compiled first.
`timescale 1ns/1ps

module tb_interrupt_vector_and_stacking_unit
    import ivsu_pkg::*;
;
    localparam ivsu_cpu_regs_t REGS = '{16'h1234, 16'h5678, 16'h9abc, 8'hde, 8'hf0};
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, tap_data_i = 8'h00, rx_data_i = 8'h00, sb [9];
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wb_ack_o, irq_o, irq_pin_n_i, nonmaskable_request_pin_n_i, watchdog_fail_i, clock_monitor_fail_i;
    logic soft_trap_i = 1'b0, illegal_op_i = 1'b0, insn_done_i = 1'b0, tap_i = 1'b0, rx_full_set_i = 1'b0;
    logic [15:0] periph_req_i, new_sp_o, a0;
    logic cpu_hold_o, gmask_o, nmask_o;
    ivsu_stack_wr_t stk_o;
    ivsu_vec_fetch_t vec_o;
    int n_fail = 0, check_count = 0, nb = 0;

    // handler reloads stack pointer: sp_i stays fixed
    ivsu_top ivsu_top_i (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .irq_pin_n_i, .nonmaskable_request_pin_n_i, .periph_req_i,
        .watchdog_fail_i, .clock_monitor_fail_i, .soft_trap_i, .illegal_op_i, .op_addr_i(16'h4321),
        .insn_done_i, .tap_i, .tap_data_i, .cpu_regs_i(REGS), .sp_i(16'h00ff), .rx_full_set_i, .rx_data_i,
        .stk_o, .vec_o, .new_sp_o, .cpu_hold_o, .gmask_o, .nmask_o);
    ivsu_src_model ivsu_src_model_i (.clk_i, .periph_req_o(periph_req_i), .irq_pin_n_o(irq_pin_n_i),
        .nmr_pin_n_o(nonmaskable_request_pin_n_i), .wd_fail_o(watchdog_fail_i), .cm_fail_o(clock_monitor_fail_i));

    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One classic bus cycle, held until ack
    task automatic wb_io(input logic [7:0] a, input logic we, input logic [31:0] d);
        int k;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'h1};
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (k == 20) begin
            n_fail++;
            conclude();
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        @(posedge clk_i);
    endtask : wb_io

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb_io(a, 1'b0, 32'h0);
        chk(q, exp);
    endtask : rd_chk

    task automatic tap(input logic [7:0] d);
        {tap_i, tap_data_i} <= {1'b1, d};
        @(posedge clk_i);
        tap_i <= 1'b0;
        @(posedge clk_i);
    endtask : tap

    // Ends instructions until entry; ev of zero expects no entry
    task automatic run_svc(input logic [15:0] ev);
        int k;
        nb = 0;
        insn_done_i <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_i);
            if (cpu_hold_o === 1'b1) insn_done_i <= 1'b0;
            if (stk_o.valid === 1'b1 && nb < 9) begin
                if (nb == 0) a0 = stk_o.addr;
                sb[nb] = stk_o.data;
                nb++;
            end
            if (vec_o.valid === 1'b1) break;
        end
        insn_done_i <= 1'b0;
        if (ev == 16'h0) chk({nb[30:0], cpu_hold_o}, 32'h0);
        else if (k == 40) begin
            n_fail++;
            conclude();
        end else chk(32'(vec_o), {15'h0, 1'b1, ev});
        @(posedge clk_i);
    endtask : run_svc

    task automatic chk_stack(input logic [7:0] codes);
        logic [7:0] e [9];
        e = '{8'h34, 8'h12, 8'h78, 8'h56, 8'hbc, 8'h9a, 8'hde, 8'hf0, codes};
        chk({nb[15:0], a0}, 32'h000900ff);
        for (int i = 0; i < 9; i++) chk({24'h0, sb[i]}, {24'h0, e[i]});
    endtask : chk_stack

    task automatic trap(input logic ill, input logic [15:0] ev);
        {illegal_op_i, soft_trap_i} <= {ill, !ill};
        @(posedge clk_i);
        {illegal_op_i, soft_trap_i} <= 2'b00;
        run_svc(ev);
    endtask : trap

    task automatic t_reset();
        for (int k = 0; k < 10 && vec_o.valid !== 1'b1; k++) @(posedge clk_i);
        chk(32'(vec_o), {15'h0, 1'b1, VEC_RESET});
        @(posedge clk_i);
        rd_chk(ADR_CC, 32'h50);
        rd_chk(ADR_PRIO, 32'h06);
        chk({30'h0, nmask_o, gmask_o}, 32'h3);
        $display("reset test done");
    endtask : t_reset

    task automatic t_mask();
        ivsu_src_model_i.set_lines(16'h0021, 1'b1, 1'b1);
        wb_io(ADR_PRIO, 1'b1, 32'h16);
        run_svc(16'h0);
        tap(8'h40);
        run_svc(16'hffd2);
        chk_stack(8'h40);
        chk({16'h0, new_sp_o}, 32'h00f6);
        rd_chk(ADR_CC, 32'h50);
        wb_io(ADR_PRIO, 1'b1, 32'h1f);
        tap(8'h40);
        wb_io(ADR_PRIO, 1'b1, 32'h16);
        run_svc(16'hffdc);
        $display("maskable test done");
    endtask : t_mask

    task automatic t_nmr();
        tap(8'h00);
        tap(8'h50);
        rd_chk(ADR_CC, 32'h10);
        tap(8'h00);
        ivsu_src_model_i.set_lines(16'h0021, 1'b0, 1'b0);
        repeat (6) @(posedge clk_i);
        run_svc(VEC_NMR);
        chk_stack(8'h00);
        rd_chk(ADR_CC, 32'h50);
        ivsu_src_model_i.set_lines(16'h0021, 1'b0, 1'b1);
        tap(8'h40);
        run_svc(16'hfff2);
        ivsu_src_model_i.set_lines(16'h0, 1'b1, 1'b1);
        $display("nonmaskable test done");
    endtask : t_nmr

    task automatic t_traps();
        trap(1'b1, VEC_ILLEGAL);
        chk({16'h0, sb[1], sb[0]}, 32'h4321);
        tap(8'h40);
        trap(1'b0, VEC_SOFT_TRAP);
        rd_chk(ADR_CC, 32'h50);
        ivsu_src_model_i.fail_pulse(1'b1, 1'b0);
        run_svc(VEC_WATCHDOG);
        ivsu_src_model_i.fail_pulse(1'b0, 1'b1);
        run_svc(VEC_CLKMON);
        chk(32'(nb), 32'h0);
        $display("trap test done");
    endtask : t_traps

    task automatic t_irq();
        wb_io(ADR_MASK, 1'b1, 32'h08);
        trap(1'b0, VEC_SOFT_TRAP);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        rd_chk(ADR_MASK, 32'h08);
        wb_io(ADR_STATUS, 1'b0, 32'h0);
        chk(q & 32'h08, 32'h08);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        wb_io(ADR_MASK, 1'b1, 32'h00);
        trap(1'b0, VEC_SOFT_TRAP);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        rd_chk(8'h1c, 32'h0);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_serial();
        {rx_full_set_i, rx_data_i} <= {1'b1, 8'ha5};
        @(posedge clk_i);
        rx_full_set_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(ADR_SER_DATA, 32'ha5);
        rd_chk(ADR_SER_STAT, 32'h1);
        rd_chk(ADR_SER_DATA, 32'ha5);
        rd_chk(ADR_SER_STAT, 32'h0);
        $display("serial test done");
    endtask : t_serial

    // Reset for five cycles, then the scenarios
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_mask();
        t_nmr();
        t_traps();
        t_irq();
        t_serial();
        conclude();
    end
endmodule : tb_interrupt_vector_and_stacking_unit
